// ---- rtl/fgx_pkg.sv ----
// Package: constants, states and field layout of the exchange block
////////////////////////////////////////////////////////////////////
package fgx_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;
  localparam int NMT_PERIOD_MS = 2000;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_NODE = 12'h004;
  localparam logic [11:0] A_SYNC = 12'h008;
  localparam logic [11:0] A_SDO = 12'h00C;
  localparam logic [11:0] A_CIDX = 12'h010;
  localparam logic [11:0] A_STAT = 12'h014;
  localparam logic [11:0] A_FBLEN = 12'h018;
  localparam logic [1:0] RG_REG = 2'h0;
  localparam logic [1:0] RG_IN = 2'h1;
  localparam logic [1:0] RG_OUT = 2'h2;
  localparam int B_SLAVE = 0;
  localparam int B_TRIG = 1;
  localparam int B_LENB = 2;
  localparam int B_SWAP = 3;
  localparam int B_SETOP = 6;
  localparam logic [7:0] FB_LEN_RST = 8'h10;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_TELEGRAM = 4'hD;
  localparam logic [2:0] SDO_IDX_HI = 3'h0;
  localparam logic [2:0] SDO_CMD = 3'h3;
  localparam logic [2:0] SDO_JOB = 3'h4;
  localparam logic [2:0] SDO_NODE = 3'h5;
  localparam logic [2:0] SDO_LEN = 3'h6;
  localparam logic [7:0] SDO_DATA = 8'h07;
  localparam logic [7:0] SDO_CMD_READ = 8'h01;
  localparam logic [7:0] SDO_STAT_OK = 8'h00;
  localparam logic [15:0] TG_HDR = 16'h0004;
  localparam logic [7:0] TRIG_POS = 8'h00;
  localparam logic [3:0] NODE_SW_CFG = 4'h0;
  typedef enum logic [3:0] {
    S_IDLE, S_PEEK, S_TXLEN, S_TXL2, S_TXRD, S_TXLD, S_TXWT,
    S_SDO_RD, S_SDO_CAP, S_SDO_WAIT, S_SDO_WB
  } fgx_fsm_e;
endpackage

// ---- rtl/fgx_mem.sv ----
// Byte buffer with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module fgx_mem #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // fgx_mem
`default_nettype wire

// ---- rtl/fgx_top.sv ----
// Gateway exchange core: SDO window, start phase, SYNC, telegrams
`timescale 1ns/1ps
`default_nettype none
module fgx_top #(
  parameter int unsigned MS_CYC = fgx_pkg::MS_CYC_DEF,
  parameter int FB_AW = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] node_switch,
  output logic [6:0] node_addr,
  input wire logic pdo_rx_valid,
  output logic nmt_start,
  output logic sync_pulse,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_last,
  output logic ser_rx_ready,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  output logic ser_tx_last,
  input wire logic ser_tx_ready,
  output logic [3:0] err_code,
  output logic sdo_req,
  output logic [15:0] sdo_index,
  output logic [7:0] sdo_sub,
  output logic [7:0] sdo_node,
  output logic sdo_read,
  input wire logic sdo_rx_valid,
  input wire logic [7:0] sdo_rx_data,
  input wire logic sdo_rx_last,
  input wire logic [7:0] sdo_rx_status
);
  import fgx_pkg::*;

  localparam logic [16:0] FB_DEPTH = 17'(1 << FB_AW);

  typedef struct packed {
    logic ap;
    logic ap_wr;
    logic [11:0] ap_addr;
    logic rdy;
    logic [31:0] rdata;
    logic resp;
    logic slave;
    logic trig;
    logic lenb;
    logic swap;
    logic [6:0] node_cfg;
    logic [6:0] node;
    logic [15:0] sync_ms;
    logic [7:0] req_idx;
    logic [7:0] rsp_idx;
    logic [7:0] ctl_idx;
    logic [7:0] fb_len;
    logic [3:0] err;
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [15:0] sync_cnt;
    logic sync;
    logic start;
    logic [10:0] nmt_cnt;
    logic nmt;
    fgx_fsm_e state;
    logic [1:0] psel;
    logic [8:0] cnt;
    logic [7:0] tlen;
    logic [7:0] trig_seen;
    logic [7:0] trig_cnt;
    logic b6_seen;
    logic [7:0] job_seen;
    logic [55:0] hdr;
    logic [7:0] got;
    logic [7:0] sstat;
    logic tx_v;
    logic [7:0] tx_d;
    logic tx_last;
    logic sdo_req;
    logic sdo_rd;
    logic [15:0] rx_n;
    logic [15:0] rx_off;
    logic [15:0] rx_len;
    logic [7:0] rx_tot;
    logic rx_ok;
    logic [1:0] post;
    logic rx_rdy;
  } fgx_state_s;

  fgx_state_s s, n;
  logic out_we;
  logic [FB_AW-1:0] out_wa;
  logic [7:0] out_wd;
  logic [FB_AW-1:0] in_ra;
  logic [7:0] in_rd;
  logic [7:0] out_rd;
  logic b6ev;
  logic rx_bad;
  logic rx_good;
  logic [15:0] rx_i;
  logic [15:0] rx_rl;
  logic [16:0] rx_end;

  function automatic logic [7:0] hb(input logic [55:0] h, input logic [2:0] k);
    logic [55:0] t;
    t = h << {k, 3'h0};
    hb = t[55:48];
  endfunction

  // Write-back order puts the job number last so the master sees a whole record
  function automatic logic [2:0] wb_pos(input logic [2:0] c);
    if (c < SDO_JOB) wb_pos = c;
    else if (c == SDO_LEN) wb_pos = SDO_JOB;
    else wb_pos = c + 3'h1;
  endfunction

  function automatic logic [7:0] lpos(input logic trig);
    lpos = {7'h0, trig};
  endfunction

  function automatic logic [7:0] mn8(input logic [7:0] a, input logic [7:0] b);
    mn8 = (a <= b) ? a : b;
  endfunction

  //////////////////////////////////////////////////////////////////
  fgx_mem #(.AW(FB_AW)) u_in (
    .clk(ref_clk),
    .we(s.ap && s.ap_wr && s.ap_addr[11:10] == RG_IN),
    .waddr(s.ap_addr[FB_AW+1:2] ^ FB_AW'(s.swap)),
    .wdata(hwdata[7:0]),
    .raddr(in_ra),
    .rdata(in_rd)
  );

  fgx_mem #(.AW(FB_AW)) u_out (
    .clk(ref_clk),
    .we(out_we),
    .waddr(out_wa),
    .wdata(out_wd),
    .raddr(haddr[FB_AW+1:2] ^ FB_AW'(s.swap)),
    .rdata(out_rd)
  );

  //////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    n.ms_tick = 1'h0;
    n.sync = 1'h0;
    n.nmt = 1'h0;
    n.sdo_req = 1'h0;
    out_we = 1'h0;
    out_wa = FB_AW'(0);
    out_wd = 8'h00;
    in_ra = FB_AW'(0);
    b6ev = 1'h0;
    rx_bad = 1'h0;
    rx_good = 1'h0;
    rx_i = s.rx_n - TG_HDR;
    rx_rl = (s.rx_n == 16'h0003) ? {s.rx_len[15:8], ser_rx_data} : s.rx_len;
    rx_end = {1'h0, s.rx_off} + {1'h0, rx_rl};
    // Bus: one wait state per transfer so out-area reads come from the RAM register
    n.ap = hsel && htrans[1] && hready;
    n.rdy = !n.ap;
    n.ap_wr = n.ap ? hwrite : s.ap_wr;
    n.ap_addr = n.ap ? haddr[11:0] : s.ap_addr;
    if (s.ap && s.ap_wr && s.ap_addr[11:10] == RG_REG) begin
      if (s.ap_addr == A_CTRL) begin
        n.slave = hwdata[B_SLAVE];
        n.trig = hwdata[B_TRIG];
        n.lenb = hwdata[B_LENB];
        n.swap = hwdata[B_SWAP];
      end else if (s.ap_addr == A_NODE) n.node_cfg = hwdata[6:0];
      else if (s.ap_addr == A_SYNC) n.sync_ms = hwdata[15:0];
      else if (s.ap_addr == A_SDO) begin
        n.req_idx = hwdata[7:0];
        n.rsp_idx = hwdata[15:8];
      end else if (s.ap_addr == A_CIDX) n.ctl_idx = hwdata[7:0];
      else if (s.ap_addr == A_STAT) n.err = ERR_NONE;
      else if (s.ap_addr == A_FBLEN) n.fb_len = hwdata[7:0];
    end
    if (s.ap && !s.ap_wr) begin
      if (s.ap_addr[11:10] == RG_OUT) n.rdata = {24'h0, out_rd};
      else if (s.ap_addr == A_CTRL) n.rdata = {28'h0, s.swap, s.lenb, s.trig, s.slave};
      else if (s.ap_addr == A_NODE) n.rdata = {25'h0, s.node_cfg};
      else if (s.ap_addr == A_SYNC) n.rdata = {16'h0, s.sync_ms};
      else if (s.ap_addr == A_SDO) n.rdata = {16'h0, s.rsp_idx, s.req_idx};
      else if (s.ap_addr == A_CIDX) n.rdata = {24'h0, s.ctl_idx};
      else if (s.ap_addr == A_STAT) n.rdata = {16'h0, s.trig_cnt, 3'h0, s.err, s.start};
      else if (s.ap_addr == A_FBLEN) n.rdata = {24'h0, s.fb_len};
      else n.rdata = 32'h0;
    end
    n.node = (node_switch == NODE_SW_CFG) ? s.node_cfg : {3'h0, node_switch};
    // Time base and SYNC
    if (s.ms_cnt == 16'(MS_CYC - 1)) begin
      n.ms_cnt = 16'h0;
      n.ms_tick = 1'h1;
    end else begin
      n.ms_cnt = s.ms_cnt + 16'h1;
    end
    if (s.sync_ms == 16'h0) begin
      n.sync_cnt = 16'h0;
    end else if (s.ms_tick) begin
      if (s.sync_cnt >= s.sync_ms - 16'h1) begin
        n.sync_cnt = 16'h0;
        n.sync = 1'h1;
      end else begin
        n.sync_cnt = s.sync_cnt + 16'h1;
      end
    end
    if (s.ms_tick && s.start) begin
      n.nmt_cnt = (s.nmt_cnt == 11'(NMT_PERIOD_MS - 1)) ? 11'h0 : s.nmt_cnt + 11'h1;
    end
    // No timeout: only a mapped PDO closes the start phase
    if (pdo_rx_valid) n.start = 1'h0;
    // Exchange sequencer
    case (s.state)
      S_IDLE: begin
        if (s.rx_ok && !s.trig) begin
          n.rx_ok = 1'h0;
          n.state = S_TXLEN;
        end else if (s.post == 2'h0) begin
          if (s.psel == 2'h0) in_ra = FB_AW'(TRIG_POS);
          else if (s.psel == 2'h1) in_ra = FB_AW'(s.ctl_idx);
          else in_ra = FB_AW'(s.req_idx + {5'h0, SDO_JOB});
          n.state = S_PEEK;
        end
      end
      S_PEEK: begin
        n.psel = (s.psel == 2'h2) ? 2'h0 : s.psel + 2'h1;
        n.state = S_IDLE;
        if (s.psel == 2'h0) begin
          // Tracked in every mode so enabling trigger mode sends nothing stale
          if (in_rd != s.trig_seen) begin
            n.trig_seen = in_rd;
            if (s.trig) n.state = S_TXLEN;
          end
        end else if (s.psel == 2'h1) begin
          if (in_rd[B_SETOP] != s.b6_seen) begin
            n.b6_seen = in_rd[B_SETOP];
            b6ev = 1'h1;
          end
        end else if (in_rd != s.job_seen && s.rx_n == 16'h0) begin
          n.cnt = 9'h0;
          n.state = S_SDO_RD;
        end
      end
      S_TXLEN: begin
        in_ra = FB_AW'(lpos(s.trig));
        n.state = S_TXL2;
      end
      S_TXL2: begin
        n.tlen = s.lenb ? in_rd : s.fb_len;
        n.cnt = 9'h0;
        n.state = (n.tlen == 8'h00) ? S_IDLE : S_TXRD;
      end
      S_TXRD: begin
        in_ra = FB_AW'(lpos(s.trig) + {7'h0, s.lenb} + s.cnt[7:0]);
        n.state = S_TXLD;
      end
      S_TXLD: begin
        n.tx_v = 1'h1;
        n.tx_d = in_rd;
        n.tx_last = (s.cnt[7:0] + 8'h1 == s.tlen);
        n.state = S_TXWT;
      end
      S_TXWT: begin
        if (ser_tx_ready) begin
          n.tx_v = 1'h0;
          n.cnt = s.cnt + 9'h1;
          n.state = s.tx_last ? S_IDLE : S_TXRD;
        end
      end
      S_SDO_RD: begin
        in_ra = FB_AW'(s.req_idx + s.cnt[7:0]);
        n.state = S_SDO_CAP;
      end
      S_SDO_CAP: begin
        n.hdr = {s.hdr[47:0], in_rd};
        if (s.cnt[2:0] == SDO_LEN) begin
          n.sdo_req = 1'h1;
          n.sdo_rd = hb(n.hdr, SDO_CMD) == SDO_CMD_READ;
          n.got = 8'h00;
          n.state = S_SDO_WAIT;
        end else begin
          n.cnt = s.cnt + 9'h1;
          n.state = S_SDO_RD;
        end
      end
      S_SDO_WAIT: begin
        if (sdo_rx_valid) begin
          if (s.got < hb(s.hdr, SDO_LEN)) begin
            out_we = 1'h1;
            out_wa = FB_AW'(s.rsp_idx + SDO_DATA + s.got);
            out_wd = sdo_rx_data;
          end
          if (s.got != 8'hFF) n.got = s.got + 8'h1;
          if (sdo_rx_last) begin
            n.sstat = sdo_rx_status;
            n.cnt = 9'h0;
            n.state = S_SDO_WB;
          end
        end
      end
      S_SDO_WB: begin
        out_we = 1'h1;
        out_wa = FB_AW'(s.rsp_idx + {5'h0, wb_pos(s.cnt[2:0])});
        if (wb_pos(s.cnt[2:0]) == SDO_CMD) out_wd = s.sstat;
        else if (wb_pos(s.cnt[2:0]) == SDO_LEN) out_wd = mn8(s.got, hb(s.hdr, SDO_LEN));
        else out_wd = hb(s.hdr, wb_pos(s.cnt[2:0]));
        n.cnt = s.cnt + 9'h1;
        if (s.cnt[2:0] == SDO_LEN) begin
          n.job_seen = hb(s.hdr, SDO_JOB);
          n.state = S_IDLE;
        end
      end
      default: n.state = S_IDLE;
    endcase
    n.nmt = (s.start && s.ms_tick && s.nmt_cnt == 11'h0 && !s.slave) || b6ev;
    // Telegram receiver: header first, then data into the out area
    if (s.post == 2'h1) begin
      out_we = 1'h1;
      out_wa = FB_AW'(TRIG_POS);
      out_wd = s.trig_cnt;
      n.post = s.lenb ? 2'h2 : 2'h0;
    end else if (s.post == 2'h2) begin
      out_we = 1'h1;
      out_wa = FB_AW'(lpos(s.trig));
      out_wd = s.rx_tot;
      n.post = 2'h0;
    end else if (ser_rx_valid && s.rx_rdy) begin
      if (s.rx_n == 16'h0000) n.rx_off[15:8] = ser_rx_data;
      else if (s.rx_n == 16'h0001) n.rx_off[7:0] = ser_rx_data;
      else if (s.rx_n == 16'h0002) n.rx_len[15:8] = ser_rx_data;
      else if (s.rx_n == 16'h0003) n.rx_len[7:0] = ser_rx_data;
      else if (rx_i < s.rx_len && {1'h0, s.rx_off} + {1'h0, rx_i} < FB_DEPTH) begin
        out_we = 1'h1;
        out_wa = FB_AW'(s.rx_off + rx_i);
        out_wd = ser_rx_data;
      end
      n.rx_n = s.rx_n + 16'h1;
      if (ser_rx_last) begin
        n.rx_n = 16'h0;
        n.rx_tot = 8'(s.rx_n + 16'h1);
        // Bytes past the count are ignored, so a zero-count request is valid
        if ({1'h0, s.rx_n} + 17'h1 >= {1'h0, TG_HDR} + {1'h0, rx_rl} && rx_end <= FB_DEPTH) begin
          rx_good = 1'h1;
          // No reply queued in trigger mode, else leaving it would send a stale one
          n.rx_ok = !s.trig;
          if (s.trig) n.trig_cnt = s.trig_cnt + 8'h1;
          n.post = s.trig ? 2'h1 : (s.lenb ? 2'h2 : 2'h0);
        end else begin
          rx_bad = 1'h1;
        end
      end
    end
    if (rx_bad) n.err = ERR_TELEGRAM;
    // Receiver stalls while the SDO path or post writes own the out-area port
    n.rx_rdy = n.post == 2'h0 && !(n.state inside {S_SDO_RD, S_SDO_CAP, S_SDO_WAIT, S_SDO_WB});
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.rdy <= 1'h1;
      s.state <= S_IDLE;
      s.fb_len <= FB_LEN_RST;
      s.start <= 1'h1;
      s.rx_rdy <= 1'h1;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.rdy;
  assign hresp = s.resp;
  assign node_addr = s.node;
  assign nmt_start = s.nmt;
  assign sync_pulse = s.sync;
  assign ser_rx_ready = s.rx_rdy;
  assign ser_tx_valid = s.tx_v;
  assign ser_tx_data = s.tx_d;
  assign ser_tx_last = s.tx_last;
  assign err_code = s.err;
  assign sdo_req = s.sdo_req;
  assign sdo_index = {hb(s.hdr, SDO_IDX_HI), s.hdr[47:40]};
  assign sdo_sub = s.hdr[39:32];
  assign sdo_node = hb(s.hdr, SDO_NODE);
  assign sdo_read = s.sdo_rd;

  //////////////////////////////////////////////////////////////////
  AST_NODE_SEL: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'h1 |=> s.node == (($past(node_switch) == NODE_SW_CFG) ?
      $past(s.node_cfg) : {3'h0, $past(node_switch)}))
    else $error("node address not chosen by switch");
  AST_SLAVE_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.slave && !b6ev) |=> !s.nmt)
    else $error("start command sent in slave mode");
  AST_SETOP_RESEND: assert property (@(posedge ref_clk) disable iff (!rstn)
    b6ev |=> s.nmt)
    else $error("control bit change did not resend start");
  AST_START_EXIT: assert property (@(posedge ref_clk) disable iff (!rstn)
    pdo_rx_valid |=> !s.start ##1 !s.start)
    else $error("start phase not left on PDO");
  AST_SYNC_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.sync_ms == 16'h0) [*2] |=> !s.sync)
    else $error("SYNC sent while disabled");
  AST_ERR13: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_bad |=> err_code == ERR_TELEGRAM)
    else $error("invalid telegram not flagged");
  AST_TRIG_INC: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rx_good && s.trig) |=> s.trig_cnt == $past(s.trig_cnt) + 8'h1 && out_we &&
      out_wd == s.trig_cnt)
    else $error("trigger byte not advanced");
  AST_TRIG_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.state == S_PEEK && s.psel == 2'h0 && s.trig && in_rd == s.trig_seen)
      |=> s.state == S_IDLE)
    else $error("send without trigger change");
  AST_SDO_TRUNC: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.state == S_SDO_WAIT && out_we) |-> s.got < hb(s.hdr, SDO_LEN))
    else $error("SDO data beyond requested length");
  AST_SDO_LEN: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.state == S_SDO_WB && s.cnt[2:0] == 3'h5) |->
      out_wd <= hb(s.hdr, SDO_LEN) && (s.got > hb(s.hdr, SDO_LEN) || out_wd == s.got))
    else $error("SDO length field wrong");
endmodule // fgx_top
`default_nettype wire

// ---- tb/fgx_peer.sv ----
// Second bus side model: sends update telegrams and collects the replies
`timescale 1ns/1ps
`default_nettype none
module fgx_peer #(
  parameter int TMO = 1000
) (
  input wire logic ref_clk,
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_last,
  input wire logic ser_rx_ready,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_last,
  output logic ser_tx_ready
);
  logic [7:0] rxq[$];
  logic [1:0] ph = 2'h0;
  int frames = 0;
  int stalls = 0;
  int tmos = 0;
  initial begin
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'h00;
    ser_rx_last = 1'b0;
  end
  // Refuses one cycle in three so replies meet back-pressure
  assign ser_tx_ready = (ph != 2'h2);
  always @(posedge ref_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ser_tx_valid === 1'b1 && ser_tx_ready) begin
      rxq.push_back(ser_tx_data);
      if (ser_tx_last === 1'b1) frames++;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Header always sent, even for an empty or repeated transfer
  task automatic send(input logic [7:0] b[$]);
    int k;
    for (int i = 0; i < b.size(); i++) begin
      @(posedge ref_clk);
      ser_rx_valid <= 1'b1;
      ser_rx_data <= b[i];
      ser_rx_last <= (i == b.size() - 1);
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (ser_rx_ready !== 1'b1 && k < 1000);
      if (k >= 1000) stalls++;
      ser_rx_valid <= 1'b0;
      ser_rx_data <= ~b[i];
      ser_rx_last <= 1'b0;
    end
  endtask
  // Empty request; on no reply the partial data is dropped and it is resent
  task automatic poll();
    int f;
    for (int r = 0; r < 2; r++) begin
      f = frames;
      rxq.delete();
      send('{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF});
      for (int t = 0; t < TMO && frames == f; t++) @(posedge ref_clk);
      if (frames != f) return;
      tmos++;
    end
  endtask
endmodule // fgx_peer
`default_nettype wire

// ---- tb/fieldbus_gateway_exchange_bench.sv ----
// Bench: registers, start phase, SYNC, SDO window, telegrams and buffer modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h expected %0h", $time, (a), (e)); end end
`define WT(c, b) begin for (int k_ = 0; k_ < (b) && !(c); k_++) @(posedge ref_clk); \
  if (!(c)) begin failures++; $display("[ERR] %0t wait ran out", $time); complete_run(); end end
module fieldbus_gateway_exchange_bench;
  import fgx_pkg::*;
  localparam int MS = 5;
  localparam int PER = NMT_PERIOD_MS * MS;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r, v;
  logic hreadyout, hresp, nmt_start, sync_pulse, sdo_req, sdo_read;
  logic rxv, rxl, rxr, txv, txl, txr;
  logic [7:0] rxd, txd, sdo_sub, sdo_node;
  logic [3:0] node_switch = 4'h0;
  logic [3:0] err_code;
  logic [6:0] node_addr;
  logic [15:0] sdo_index;
  logic pdo_rx_valid = 1'b0;
  logic sdo_rx_valid = 1'b0;
  logic sdo_rx_last = 1'b0;
  logic [7:0] sdo_rx_data = 8'h00;
  logic [7:0] sdo_rx_status = 8'h00;
  logic [7:0] e1[9] = '{8'h10, 8'h09, 8'h00, 8'h00, 8'h01, 8'h05, 8'h02, 8'h47, 8'h48};
  logic [7:0] e2[8] = '{8'hA0, 8'hA1, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hA7};
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0, n_nmt = 0, n_sync = 0, nmt_at = 0, sync_at = 0, nmt_gap = 0, sync_gap = 0, n, f;
  always #12.5 ref_clk = ~ref_clk;
  fgx_top #(.MS_CYC(MS), .FB_AW(8)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .node_switch(node_switch), .node_addr(node_addr), .pdo_rx_valid(pdo_rx_valid),
    .nmt_start(nmt_start), .sync_pulse(sync_pulse), .ser_rx_valid(rxv), .ser_rx_data(rxd),
    .ser_rx_last(rxl), .ser_rx_ready(rxr), .ser_tx_valid(txv), .ser_tx_data(txd),
    .ser_tx_last(txl), .ser_tx_ready(txr), .err_code(err_code), .sdo_req(sdo_req),
    .sdo_index(sdo_index), .sdo_sub(sdo_sub), .sdo_node(sdo_node), .sdo_read(sdo_read),
    .sdo_rx_valid(sdo_rx_valid), .sdo_rx_data(sdo_rx_data), .sdo_rx_last(sdo_rx_last),
    .sdo_rx_status(sdo_rx_status));
  fgx_peer #(.TMO(4000 * MS)) peer_u (.ref_clk(ref_clk), .ser_rx_valid(rxv),
    .ser_rx_data(rxd), .ser_rx_last(rxl), .ser_rx_ready(rxr), .ser_tx_valid(txv),
    .ser_tx_data(txd), .ser_tx_last(txl), .ser_tx_ready(txr));
  always @(posedge ref_clk) begin
    cyc++;
    if (nmt_start === 1'b1) begin
      n_nmt++;
      nmt_gap = cyc - nmt_at;
      nmt_at = cyc;
    end
    if (sync_pulse === 1'b1) begin
      n_sync++;
      sync_gap = cyc - sync_at;
      sync_at = cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Holds each phase until hready is sampled high; read data taken at that edge
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) break;
    end
    `WT(k < 50, 1)
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) break;
    end
    `WT(k < 50, 1)
    r = hrdata;
  endtask
  task automatic wi(input int i, input logic [7:0] d);
    ahb(1'b1, 12'h400 + 12'(4 * i), {24'h0, d});
  endtask
  task automatic ro(input int i);
    ahb(1'b0, 12'h800 + 12'(4 * i), 32'h0);
  endtask
  task automatic tg(input logic [15:0] off, cnt, input int nd, input logic [7:0] base, input int rn);
    logic [7:0] b[$];
    b = '{off[15:8], off[7:0], cnt[15:8], cnt[7:0]};
    for (int k = 0; k < nd; k++) b.push_back(base + 8'(k));
    peer_u.rxq.delete();
    f = peer_u.frames;
    peer_u.send(b);
    if (rn > 0) `WT(peer_u.frames != f, 500)
    else repeat (150) @(posedge ref_clk);
    `CHK(peer_u.rxq.size(), rn)
  endtask
  task automatic sdo_feed(input logic [7:0] b[$]);
    `WT(sdo_req === 1'b1, 2000)
    foreach (b[i]) begin
      @(posedge ref_clk);
      sdo_rx_valid <= 1'b1;
      sdo_rx_data <= b[i];
      sdo_rx_last <= (i == b.size() - 1);
    end
    @(posedge ref_clk);
    sdo_rx_valid <= 1'b0;
    sdo_rx_last <= 1'b0;
    sdo_rx_data <= ~b[b.size() - 1];
    repeat (40) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    `CHK(hreadyout, 1'b1)
    ahb(1'b1, A_CTRL, 32'h1);
    ahb(1'b0, A_STAT, 32'h0);
    `CHK(r[4:0], 5'h01)
    ahb(1'b0, A_FBLEN, 32'h0);
    `CHK(r[7:0], FB_LEN_RST)
    ahb(1'b0, 12'hFFC, 32'h0);
    `CHK(r, 32'h0)
    ahb(1'b1, A_NODE, 32'h23);
    repeat (2) @(posedge ref_clk);
    `CHK(node_addr, 7'h23)
    node_switch <= 4'h5;
    repeat (3) @(posedge ref_clk);
    `CHK(node_addr, 7'h05)
    ahb(1'b1, A_SYNC, 32'h3);
    `WT(n_sync >= 2, 100)
    `CHK(sync_gap, 3 * MS)
    ahb(1'b1, A_SYNC, 32'h0);
    @(posedge ref_clk);
    n = n_sync;
    repeat (100) @(posedge ref_clk);
    `CHK(n_sync, n)
    repeat (PER + 500) @(posedge ref_clk);
    `CHK(n_nmt, 0)
    ahb(1'b1, A_CTRL, 32'h0);
    `WT(n_nmt >= 2, 2 * PER + 100)
    `CHK(nmt_gap, PER)
    @(posedge ref_clk);
    pdo_rx_valid <= 1'b1;
    @(posedge ref_clk);
    pdo_rx_valid <= 1'b0;
    ahb(1'b0, A_STAT, 32'h0);
    `CHK(r[0], 1'b0)
    n = n_nmt;
    repeat (PER + 100) @(posedge ref_clk);
    `CHK(n_nmt, n)
    // Request index set first, then the job byte cleared before the record is written
    ahb(1'b1, A_SDO, 32'h2020);
    wi(8'h24, 8'h00);
    for (int k = 0; k < 7; k++) if (k != 4) wi(8'h20 + k, e1[k] | ((k == 3) ? 8'h01 : 8'h00));
    wi(8'h24, 8'h01);
    sdo_feed('{8'h47, 8'h48, 8'h49});
    `CHK({sdo_index, sdo_sub, sdo_node, sdo_read}, {16'h1009, 8'h00, 8'h05, 1'b1})
    for (int k = 0; k < 9; k++) begin
      ro(8'h20 + k);
      `CHK(r[7:0], e1[k])
    end
    wi(8'h26, 8'h04);
    wi(8'h24, 8'h02);
    sdo_feed('{8'h55});
    ro(8'h26);
    `CHK(r[7:0], 8'h01)
    ro(8'h24);
    `CHK(r[7:0], 8'h02)
    for (int k = 0; k < 16; k++) wi(k, 8'h30 + 8'(k));
    tg(16'h0, 16'h8, 8, 8'hA0, 16);
    tg(16'h2, 16'h5, 5, 8'h01, 16);
    for (int k = 0; k < 16; k++) `CHK(peer_u.rxq[k], 8'h30 + 8'(k))
    for (int k = 0; k < 8; k++) begin
      ro(k);
      `CHK(r[7:0], e2[k])
    end
    f = peer_u.frames;
    peer_u.poll();
    `CHK({peer_u.frames - f, peer_u.tmos, int'(peer_u.rxq.size())}, {32'd1, 32'd0, 32'd16})
    f = peer_u.frames;
    peer_u.send('{8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h02});
    `WT(err_code === ERR_TELEGRAM, 50)
    `CHK(err_code, ERR_TELEGRAM)
    repeat (150) @(posedge ref_clk);
    `CHK(peer_u.frames, f)
    ahb(1'b1, A_STAT, 32'h0);
    `CHK(err_code, ERR_NONE)
    ahb(1'b1, A_CTRL, 32'h8);
    ro(2);
    `CHK(r[7:0], 8'h02)
    ro(3);
    `CHK(r[7:0], 8'h01)
    ahb(1'b1, A_CTRL, 32'h4);
    wi(0, 8'h03);
    tg(16'h4, 16'h2, 2, 8'hC0, 3);
    `CHK({peer_u.rxq[0], peer_u.rxq[1], peer_u.rxq[2]}, 24'h313233)
    ro(0);
    `CHK(r[7:0], 8'h06)
    ahb(1'b1, A_CTRL, 32'h2);
    ahb(1'b0, A_STAT, 32'h0);
    v = r;
    tg(16'h8, 16'h1, 1, 8'hD0, 0);
    ahb(1'b0, A_STAT, 32'h0);
    `CHK(r[15:8], v[15:8] + 8'h01)
    v = r;
    ro(0);
    `CHK(r[7:0], v[15:8])
    peer_u.rxq.delete();
    f = peer_u.frames;
    wi(0, 8'h99);
    `WT(peer_u.frames != f, 500)
    `CHK({int'(peer_u.rxq.size()), peer_u.rxq[0]}, {32'd16, 8'h31})
    ahb(1'b1, A_CTRL, 32'h0);
    ahb(1'b1, A_CIDX, 32'h3);
    repeat (20) @(posedge ref_clk);
    n = n_nmt;
    wi(3, 8'h73);
    `WT(n_nmt != n, 50)
    `CHK(n_nmt, n + 1)
    `CHK({peer_u.stalls, hresp}, {32'd0, 1'b0})
    complete_run();
  end
endmodule // fieldbus_gateway_exchange_bench
`default_nettype wire
